// *** logic/irq_agg_cfg.svh ***
// command codes, field positions and reset values of the interrupt summary block
`ifndef IRQ_AGG_CFG_SVH
`define IRQ_AGG_CFG_SVH

// ----------------------------------------
// command codes
// ----------------------------------------
`define CMD_SUMMARY        8'h00
`define CMD_MASK           8'h01

// ----------------------------------------
// summary and mask bit positions
// ----------------------------------------
`define BIT_SUPPLY         7
`define BIT_START          6
`define BIT_OVERCURRENT    5
`define BIT_CLASSIFY       4
`define BIT_DETECT         3
`define BIT_DISCONNECT     2
`define BIT_POWER_GOOD     1
`define BIT_POWER_ENABLE   0

// ----------------------------------------
// reset values and unmapped read value
// ----------------------------------------
`define SUMMARY_RST        8'h80
`define MASK_RST           8'h80
`define UNMAPPED_READ      8'h00

`endif

// *** logic/irq_agg_pkg.sv ***
// types shared by the interrupt summary block
package irq_agg_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef logic [3:0] chan_flags_t;
endpackage

// *** logic/pse_irq_aggregator.sv ***
// interrupt summary flags, mask register and active-low interrupt output
`include "irq_agg_cfg.svh"

// Notes on behaviour
// - bit 7 ORs supply faults, resets to 1
// - bit 6 ORs the start-timeout flags
// - bit 5 ORs overload-cut and current-limit flags
// - bit 4 ORs classification event flags
// - bit 3 ORs detection event flags
// - bit 2 ORs disconnect event flags
// - bit 1 ORs power-good change flags
// - bit 0 ORs power-enable change flags
// - mask register read/write at code 01h
// - mask bit 0 blocks its flag
// - summary flags ignore the mask entirely
// - interrupt needs unmasked flag and global enable
// - mask resets to 80h
// - flags clear when their sources clear
// - summary readable only, at code 00h
// - emptied event register releases the interrupt
module pse_irq_aggregator (
    // clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      rst_b,
    // supply, thermal and memory fault sources
    input  wire logic                      thermal_shutdown_flag,
    input  wire logic                      logic_supply_undervolt,
    input  wire logic                      logic_supply_warning,
    input  wire logic                      power_supply_undervolt,
    input  wire logic                      memory_fault_flag,
    // per-channel event sources, bit n is channel n+1
    input  wire irq_agg_pkg::chan_flags_t  start_timeout_ch,
    input  wire irq_agg_pkg::chan_flags_t  overload_cut_ch,
    input  wire irq_agg_pkg::chan_flags_t  current_limit_ch,
    input  wire irq_agg_pkg::chan_flags_t  classify_event_ch,
    input  wire irq_agg_pkg::chan_flags_t  detect_event_ch,
    input  wire irq_agg_pkg::chan_flags_t  disconnect_event_ch,
    input  wire irq_agg_pkg::chan_flags_t  power_good_event_ch,
    input  wire irq_agg_pkg::chan_flags_t  power_enable_event_ch,
    // global enable from the general mask register
    input  wire logic                      global_irq_enable,
    // register command port
    input  wire irq_agg_pkg::reg_byte_t    cmd_code,
    input  wire logic                      cmd_wr,
    input  wire logic                      cmd_rd,
    input  wire irq_agg_pkg::reg_byte_t    cmd_wr_data,
    output logic [7:0]                     cmd_rd_data,
    output logic                           cmd_rd_valid,
    // interrupt line to the host
    output logic                           irq_b
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic any4(input irq_agg_pkg::chan_flags_t f);
        any4 = |f;
    endfunction

    // ----------------------------------------
    // summary sources
    // ----------------------------------------
    wire logic                   supply_fault_any;
    wire logic                   start_timeout_any;
    wire logic                   overcurrent_any;
    wire logic                   classify_cycle_any;
    wire logic                   detect_cycle_any;
    wire logic                   disconnect_any;
    wire logic                   power_good_change_any;
    wire logic                   power_enable_change_any;
    wire irq_agg_pkg::reg_byte_t summary_d;

    assign supply_fault_any        = thermal_shutdown_flag | logic_supply_undervolt | logic_supply_warning
                                   | power_supply_undervolt | memory_fault_flag;
    assign start_timeout_any       = any4(start_timeout_ch);
    assign overcurrent_any         = any4(overload_cut_ch) | any4(current_limit_ch);
    assign classify_cycle_any      = any4(classify_event_ch);
    assign detect_cycle_any        = any4(detect_event_ch);
    assign disconnect_any          = any4(disconnect_event_ch);
    assign power_good_change_any   = any4(power_good_event_ch);
    assign power_enable_change_any = any4(power_enable_event_ch);

    // the flags mirror their sources, so a clear-on-read or a global event reset
    // upstream clears them on the next edge and a new event is never lost here
    assign summary_d = {supply_fault_any, start_timeout_any, overcurrent_any, classify_cycle_any,
                        detect_cycle_any, disconnect_any, power_good_change_any,
                        power_enable_change_any};

    // ----------------------------------------
    // registers
    // ----------------------------------------
    irq_agg_pkg::reg_byte_t summary_q;
    irq_agg_pkg::reg_byte_t mask_q;
    logic                   irq_b_q;
    logic [7:0]             rd_data_q;
    logic                   rd_valid_q;

    wire logic                   mask_wr;
    wire logic                   irq_active;
    wire irq_agg_pkg::reg_byte_t rd_mux;

    assign mask_wr    = cmd_wr && (cmd_code == `CMD_MASK);
    assign irq_active = (|(summary_q & mask_q)) && global_irq_enable;
    // writes to the summary code fall through: it is read only
    assign rd_mux     = (cmd_code == `CMD_SUMMARY) ? summary_q :
                        (cmd_code == `CMD_MASK)    ? mask_q    : `UNMAPPED_READ;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            summary_q <= `SUMMARY_RST;
        end else begin
            summary_q <= summary_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            mask_q <= `MASK_RST;
        end else if (mask_wr) begin
            mask_q <= cmd_wr_data;
        end
    end

    // registered pin keeps glitches off the host line; costs one cycle of latency
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            irq_b_q <= 1'b1;
        end else begin
            irq_b_q <= ~irq_active;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rd_data_q  <= 8'h00;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= cmd_rd;
            if (cmd_rd) begin
                rd_data_q <= rd_mux;
            end
        end
    end

    assign cmd_rd_data  = rd_data_q;
    assign cmd_rd_valid = rd_valid_q;
    assign irq_b        = irq_b_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_supply_flag_set: assert property (@(posedge ref_clk) disable iff (!rst_b)
        supply_fault_any |=> summary_q[`BIT_SUPPLY])
        else $error("supply summary bit missed a fault");

    a_start_flag_or: assert property (@(posedge ref_clk) disable iff (!rst_b)
        ##1 summary_q[`BIT_START] == |$past(start_timeout_ch))
        else $error("start summary bit not the OR of channels");

    a_overcur_flag_or: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (|overload_cut_ch || |current_limit_ch) |=> summary_q[`BIT_OVERCURRENT])
        else $error("overcurrent summary bit missed an event");

    a_overcur_flag_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (overload_cut_ch == 4'h0 && current_limit_ch == 4'h0) |=> !summary_q[`BIT_OVERCURRENT])
        else $error("overcurrent summary bit set without cause");

    a_classify_flag_or: assert property (@(posedge ref_clk) disable iff (!rst_b)
        ##1 summary_q[`BIT_CLASSIFY] == |$past(classify_event_ch))
        else $error("classify summary bit wrong");

    a_detect_flag_or: assert property (@(posedge ref_clk) disable iff (!rst_b)
        ##1 summary_q[`BIT_DETECT] == |$past(detect_event_ch))
        else $error("detect summary bit wrong");

    a_discon_flag_or: assert property (@(posedge ref_clk) disable iff (!rst_b)
        ##1 summary_q[`BIT_DISCONNECT] == |$past(disconnect_event_ch))
        else $error("disconnect summary bit wrong");

    a_pgood_flag_or: assert property (@(posedge ref_clk) disable iff (!rst_b)
        ##1 summary_q[`BIT_POWER_GOOD] == |$past(power_good_event_ch))
        else $error("power-good summary bit wrong");

    a_penable_flag_or: assert property (@(posedge ref_clk) disable iff (!rst_b)
        ##1 summary_q[`BIT_POWER_ENABLE] == |$past(power_enable_event_ch))
        else $error("power-enable summary bit wrong");

    a_mask_write_read: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (cmd_wr && cmd_code == `CMD_MASK) ##1 (cmd_rd && !cmd_wr && cmd_code == `CMD_MASK)
        |=> cmd_rd_valid && cmd_rd_data == $past(cmd_wr_data, 2))
        else $error("mask readback differs from written value");

    a_masked_no_irq: assert property (@(posedge ref_clk) disable iff (!rst_b)
        ((summary_q & mask_q) == 8'h00) |=> irq_b)
        else $error("interrupt asserted by masked flags");

    a_summary_ignores_mask: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (cmd_wr && cmd_code == `CMD_MASK) |=> summary_q == $past(summary_d))
        else $error("mask write disturbed summary flags");

    a_enable_gates_irq: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (!global_irq_enable) |=> irq_b)
        else $error("interrupt asserted while globally disabled");

    a_mask_reset_value: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !$past(rst_b) |-> (mask_q == `MASK_RST && summary_q == `SUMMARY_RST))
        else $error("wrong value after reset");

    a_summary_read_only: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (cmd_wr && cmd_code == `CMD_SUMMARY) |=> $stable(mask_q))
        else $error("write to summary code changed the mask");

    a_irq_release: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (rst_b && summary_d == 8'h00) [*2] |=> irq_b)
        else $error("interrupt held after sources emptied");

    a_irq_active_low: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (|(summary_q & mask_q) && global_irq_enable) |=> !irq_b)
        else $error("interrupt not driven low for enabled flag");

endmodule // pse_irq_aggregator

// *** verif/irq_host_model.sv ***
// host model: single-byte register reads and writes on the command port
module irq_host_model (
    // clock
    input  wire logic                   ref_clk,
    // command port
    output irq_agg_pkg::reg_byte_t      cmd_code,
    output logic                        cmd_wr,
    output logic                        cmd_rd,
    output irq_agg_pkg::reg_byte_t      cmd_wr_data,
    input  wire logic [7:0]             cmd_rd_data,
    input  wire logic                   cmd_rd_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd_code = 8'h00;
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd_wr_data = 8'h00;
    end
    // one strobe cycle, released on the edge that takes it
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        @(posedge ref_clk);
        cmd_code <= c;
        cmd_wr_data <= d;
        cmd_wr <= 1'b1;
        @(posedge ref_clk);
        cmd_wr <= 1'b0;
    endtask
    // answer lands one edge after the strobe; sampled once it has settled
    task automatic rd(input logic [7:0] c, output logic [7:0] d, output logic v);
        @(posedge ref_clk);
        cmd_code <= c;
        cmd_rd <= 1'b1;
        @(posedge ref_clk);
        cmd_rd <= 1'b0;
        #1;
        v = cmd_rd_valid;
        d = cmd_rd_data;
    endtask
    // write, then read the same code back on the very next edge
    task automatic wr_rd(input logic [7:0] c, input logic [7:0] wd, output logic [7:0] d, output logic v);
        @(posedge ref_clk);
        cmd_code <= c;
        cmd_wr_data <= wd;
        cmd_wr <= 1'b1;
        @(posedge ref_clk);
        cmd_wr <= 1'b0;
        cmd_rd <= 1'b1;
        @(posedge ref_clk);
        cmd_rd <= 1'b0;
        #1;
        v = cmd_rd_valid;
        d = cmd_rd_data;
    endtask
endmodule // irq_host_model

// *** verif/pse_irq_aggregator_tb_top.sv ***
// self-checking bench for the interrupt summary block
`include "irq_agg_cfg.svh"
module pse_irq_aggregator_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                   ref_clk = 1'b0;
    logic                   rst_b = 1'b0;
    logic                   en = 1'b0;
    logic [36:0]            src = '0;
    irq_agg_pkg::reg_byte_t code, wdat;
    logic                   wr, rd, rvalid, irq_b, v;
    logic [7:0]             rdat, d;
    int                     errors = 0, checks_done = 0, cyc = 0;
    int                     lo[8] = '{33, 29, 25, 21, 17, 9, 5, 0};
    always #12.5 ref_clk = ~ref_clk;
    pse_irq_aggregator u_pse_irq_aggregator (
        .ref_clk(ref_clk), .rst_b(rst_b),
        .thermal_shutdown_flag(src[0]), .logic_supply_undervolt(src[1]), .logic_supply_warning(src[2]),
        .power_supply_undervolt(src[3]), .memory_fault_flag(src[4]),
        .start_timeout_ch(src[8:5]), .overload_cut_ch(src[12:9]), .current_limit_ch(src[16:13]),
        .classify_event_ch(src[20:17]), .detect_event_ch(src[24:21]), .disconnect_event_ch(src[28:25]),
        .power_good_event_ch(src[32:29]), .power_enable_event_ch(src[36:33]), .global_irq_enable(en),
        .cmd_code(code), .cmd_wr(wr), .cmd_rd(rd), .cmd_wr_data(wdat),
        .cmd_rd_data(rdat), .cmd_rd_valid(rvalid), .irq_b(irq_b));
    irq_host_model u_irq_host_model (
        .ref_clk(ref_clk), .cmd_code(code), .cmd_wr(wr), .cmd_rd(rd),
        .cmd_wr_data(wdat), .cmd_rd_data(rdat), .cmd_rd_valid(rvalid));
    // ----------------------------------------
    // expectations and comparisons
    // ----------------------------------------
    function automatic logic [7:0] exp_sum(input logic [36:0] s);
        return {|s[4:0], |s[8:5], |s[16:9], |s[20:17], |s[24:21], |s[28:25], |s[32:29], |s[36:33]};
    endfunction
    function automatic logic exp_irq_b(input logic [7:0] s, input logic [7:0] mk, input logic e);
        return !((|(s & mk)) && e);
    endfunction
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_byte({7'h00, got}, {7'h00, exp});
    endtask
    task automatic results;
        if (errors == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // source to irq_b takes two edges; a third lets everything settle
    task automatic chk(input logic [7:0] mk);
        repeat (3) @(posedge ref_clk);
        #1;
        cmp_bit(irq_b, exp_irq_b(exp_sum(src), mk, en));
        u_irq_host_model.rd(`CMD_SUMMARY, d, v);
        cmp_bit(v, 1'b1);
        cmp_byte(d, exp_sum(src));
        u_irq_host_model.rd(`CMD_MASK, d, v);
        cmp_byte(d, mk);
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            results();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(14896));
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        chk(`MASK_RST);
        // a write to the read-only summary and a read of an unmapped code
        u_irq_host_model.wr(`CMD_SUMMARY, 8'hff);
        chk(`MASK_RST);
        u_irq_host_model.rd(8'h05, d, v);
        cmp_byte(d, `UNMAPPED_READ);
        // back-to-back write and readback of the mask
        u_irq_host_model.wr_rd(`CMD_MASK, 8'h5a, d, v);
        cmp_bit(v, 1'b1);
        cmp_byte(d, 8'h5a);
        // one summary flag at a time: unmasked, masked, disabled, then cleared upstream
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            src <= 37'(1) << (lo[i] + $urandom_range(i == 5 ? 7 : (i == 7 ? 4 : 3)));
            en <= 1'b1;
            u_irq_host_model.wr(`CMD_MASK, 8'h01 << i);
            chk(8'h01 << i);
            u_irq_host_model.wr(`CMD_MASK, ~(8'h01 << i));
            chk(~(8'h01 << i));
            u_irq_host_model.wr(`CMD_MASK, 8'hff);
            en <= 1'b0;
            chk(8'hff);
            @(posedge ref_clk);
            src <= '0;
            en <= 1'b1;
            chk(8'hff);
        end
        // sparse random sources, random mask and enable
        for (int n = 0; n < 40; n++) begin
            @(posedge ref_clk);
            src <= 37'({$urandom, $urandom} & {$urandom, $urandom} & {$urandom, $urandom});
            en <= 1'($urandom);
            d = 8'($urandom);
            u_irq_host_model.wr(`CMD_MASK, d);
            chk(d);
        end
        results();
    end
endmodule // pse_irq_aggregator_tb_top
